/* logic/srrc_pkg.sv */
// Constants and types for the system reset and reference controller.
// Assumes a single 100 MHz system clock; fuse codes arrive as static inputs.
//
// Operation
// - While reset holds, I/O registers load initial values; run restarts at vector.
// - Port reset goes active immediately from any source but the watchdog, without a clock.
// - After all sources go inactive, internal reset is stretched by fuse-selected delay.
// - Five sources: power-on, pin, watchdog, brown-out, test-port register.
// - Power-on reset holds while supply below level; rising supply starts delay.
// - Supply drop reasserts reset at once, no stretching on assertion.
// - Low active-low pin resets even without clock; short pulses not guaranteed.
// - Pin returning high starts delay; processor released after time-out.
// - Enabled brown-out asserts reset immediately; recovery starts delay counter.
// - Watchdog expiry resets only while watchdog enabled.
// - Watchdog time-out makes one-cycle pulse; delay starts at its falling edge.
// - Reset held while test-port reset register holds one.
// - Reference enable is OR of brown-out fuse, bandgap select, converter enable.
// - Watchdog flag set on watchdog reset, cleared by power-on or software zero.
// - Power-on flag set on power-on reset, cleared only by software zero or rst_in.
`default_nettype none

package srrc_pkg;

   // ---------------------------------------------------------------
   // Delay selection
   // ---------------------------------------------------------------
   localparam int unsigned SRRC_CNT_W = 20;
   // Fuse-selected stretch lengths in cycles, index = {startup high bit, clock-select low bit}
   localparam logic [SRRC_CNT_W-1:0] SRRC_DLY_0 = 20'h00004;
   localparam logic [SRRC_CNT_W-1:0] SRRC_DLY_1 = 20'h00400;
   localparam logic [SRRC_CNT_W-1:0] SRRC_DLY_2 = 20'h01000;
   localparam logic [SRRC_CNT_W-1:0] SRRC_DLY_3 = 20'h10000;
   localparam logic [SRRC_CNT_W-1:0] SRRC_CNT_RST = 20'h00000;
   localparam logic [1:0]            SRRC_SYNC_RST = 2'h3;
   localparam logic [2:0]            SRRC_BOD_OFF  = 3'h7;

   // ---------------------------------------------------------------
   // Source bundle
   // ---------------------------------------------------------------
   typedef struct packed {
      logic por;
      logic ext;
      logic wdt;
      logic brownout_detector;
      logic tap;
   } srrc_src_t;

   typedef struct packed {
      logic wdt_flag;
      logic por_flag;
   } srrc_flags_t;

   typedef enum logic [1:0] {
      SRRC_HOLD,
      SRRC_COUNT,
      SRRC_RUN
   } srrc_state_t;

endpackage : srrc_pkg

`default_nettype wire

/* logic/srrc_top.sv */
// System reset and reference controller: merges reset sources, stretches
// internal reset, keeps reset flags and drives the bandgap enable.
// Assumes analog detectors and the pin are asynchronous; fuses are static.
`default_nettype none

module srrc_top
   import srrc_pkg::*;
(
   input  wire logic        clk_sys_in,               // System clock 100 MHz
   input  wire logic        rst_in,                   // Async reset, active high
   input  wire logic        supply_low_in,            // Supply below power-on level
   input  wire logic        ext_reset_n_in,           // External reset pin, active low
   input  wire logic        wdt_timeout_in,           // Watchdog expiry event
   input  wire logic        wdt_enable_in,            // Watchdog enabled
   input  wire logic        avcc_low_in,              // Supply below brown-out level
   input  wire logic [2:0]  brownout_level_fuse_in,   // All ones = detector off
   input  wire logic        tap_reset_in,             // Test-port reset register bit
   input  wire logic [1:0]  startup_time_fuse_in,     // Start-up time fuse
   input  wire logic [3:0]  clock_select_fuse_in,     // Clock select fuse
   input  wire logic        comparator_bandgap_select_in, // Bandgap to comparator
   input  wire logic        adc_enable_in,            // Converter enabled
   input  wire logic        wdt_flag_clr_in,          // Software writes zero to flag
   input  wire logic        por_flag_clr_in,          // Software writes zero to flag
   output logic             port_reset_out,           // Port reset, async assert except watchdog
   output logic             cpu_reset_out,            // Stretched internal reset
   output logic             ref_enable_out,           // Bandgap reference enable
   output srrc_flags_t      flags_out                 // Reset cause flags
);

   // ---------------------------------------------------------------
   // Immediate source combining
   // ---------------------------------------------------------------
   logic      bod_on;
   logic      async_src;
   logic      wdt_pulse_q;
   srrc_src_t src;

   function automatic logic [SRRC_CNT_W-1:0] delay_sel(input logic [1:0] startup_time_fuse, input logic [3:0] cks);
      case ({startup_time_fuse[1], cks[0]})
         2'h0:    delay_sel = SRRC_DLY_0;
         2'h1:    delay_sel = SRRC_DLY_1;
         2'h2:    delay_sel = SRRC_DLY_2;
         default: delay_sel = SRRC_DLY_3;
      endcase
   endfunction : delay_sel

   assign bod_on    = (brownout_level_fuse_in != SRRC_BOD_OFF);
   assign src.por   = supply_low_in;
   assign src.ext   = ~ext_reset_n_in;
   assign src.brownout_detector   = bod_on & avcc_low_in;
   assign src.tap   = tap_reset_in;
   assign src.wdt   = wdt_pulse_q;
   assign async_src = rst_in | src.por | src.ext | src.brownout_detector | src.tap;

   // ---------------------------------------------------------------
   // Watchdog pulse, one clock wide
   // ---------------------------------------------------------------
   logic wdt_prev_q;

   always_ff @(posedge clk_sys_in or posedge async_src) begin
      if (async_src) begin
         wdt_prev_q  <= 1'b0;
         wdt_pulse_q <= 1'b0;
      end else begin
         wdt_prev_q  <= wdt_timeout_in;
         wdt_pulse_q <= wdt_timeout_in & ~wdt_prev_q & wdt_enable_in;
      end
   end

   // ---------------------------------------------------------------
   // Release synchroniser: assert at once, release after two edges
   // ---------------------------------------------------------------
   logic [1:0] sync_q;

   always_ff @(posedge clk_sys_in or posedge async_src) begin
      if (async_src) begin
         sync_q <= SRRC_SYNC_RST;
      end else begin
         sync_q <= {sync_q[0], 1'b0};
      end
   end

   // Port reset follows sources other than the watchdog without a clock; flop kept for release timing
   logic port_rst_q;

   always_ff @(posedge clk_sys_in or posedge async_src) begin
      if (async_src) begin
         port_rst_q <= 1'b1;
      end else begin
         port_rst_q <= sync_q[1] | wdt_pulse_q;
      end
   end
   assign port_reset_out = port_rst_q;

   // ---------------------------------------------------------------
   // Delay counter
   // ---------------------------------------------------------------
   srrc_state_t           state_q;
   logic [SRRC_CNT_W-1:0] cnt_q;
   logic                  hold;

   // Watchdog pulse restarts the count; counting begins after its fall
   assign hold = sync_q[1] | wdt_pulse_q;

   always_ff @(posedge clk_sys_in or posedge async_src) begin
      if (async_src) begin
         state_q <= SRRC_HOLD;
         cnt_q   <= SRRC_CNT_RST;
      end else begin
         case (state_q)
            SRRC_HOLD: begin
               cnt_q <= SRRC_CNT_RST;
               if (!hold) begin
                  state_q <= SRRC_COUNT;
               end
            end
            SRRC_COUNT: begin
               if (hold) begin
                  state_q <= SRRC_HOLD;
                  cnt_q   <= SRRC_CNT_RST;
               end else if (cnt_q >= delay_sel(startup_time_fuse_in, clock_select_fuse_in) - 20'h00001) begin
                  state_q <= SRRC_RUN;
               end else begin
                  cnt_q <= cnt_q + 20'h00001;
               end
            end
            SRRC_RUN: begin
               if (hold) begin
                  state_q <= SRRC_HOLD;
               end
            end
            default: begin
               state_q <= SRRC_HOLD;
            end
         endcase
      end
   end

   // Processor sees reset until run; vector fetch follows release
   always_ff @(posedge clk_sys_in or posedge async_src) begin
      if (async_src) begin
         cpu_reset_out <= 1'b1;
      end else begin
         cpu_reset_out <= ~(state_q == SRRC_RUN) | hold;
      end
   end

   // ---------------------------------------------------------------
   // Reset flags; set wins over a software clear
   // ---------------------------------------------------------------
   logic por_seen_q;

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         flags_out  <= '0;
         por_seen_q <= 1'b0;
      end else begin
         por_seen_q <= src.por;
         if (src.por) begin
            flags_out.por_flag <= 1'b1;
         end else if (por_flag_clr_in) begin
            flags_out.por_flag <= 1'b0;
         end
         if (wdt_pulse_q) begin
            flags_out.wdt_flag <= 1'b1;
         end else if (src.por | por_seen_q | wdt_flag_clr_in) begin
            flags_out.wdt_flag <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Bandgap reference enable
   // ---------------------------------------------------------------
   // No start-up wait here: software must allow it when brown-out is off
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         ref_enable_out <= 1'b0;
      end else begin
         ref_enable_out <= bod_on | comparator_bandgap_select_in | adc_enable_in;
      end
   end

endmodule : srrc_top

`default_nettype wire

/* testbench/srrc_props.sv */
// Port checker for the reset and reference controller.
// Assumes one clock and asynchronous active-high rst_in.
`default_nettype none
module srrc_props
   import srrc_pkg::*;
(
   input wire logic        clk_sys_in,                   // Clock
   input wire logic        rst_in,                       // Reset
   input wire logic        supply_low_in,                // Supply low
   input wire logic        ext_reset_n_in,               // Pin
   input wire logic        wdt_timeout_in,               // Expiry
   input wire logic        wdt_enable_in,                // Enable
   input wire logic        avcc_low_in,                  // Brown-out
   input wire logic [2:0]  brownout_level_fuse_in,       // Fuse
   input wire logic        tap_reset_in,                 // Test port
   input wire logic        comparator_bandgap_select_in, // Select
   input wire logic        adc_enable_in,                // Converter
   input wire logic        port_reset_out,               // Port reset
   input wire logic        cpu_reset_out,                // Core reset
   input wire logic        ref_enable_out,               // Reference
   input wire srrc_flags_t flags_out                     // Flags
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   wire logic bod_on = brownout_level_fuse_in != SRRC_BOD_OFF;
   wire logic ref_c  = bod_on | comparator_bandgap_select_in | adc_enable_in;
   wire logic any_s  = supply_low_in | ~ext_reset_n_in | tap_reset_in | (bod_on & avcc_low_in);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);
   pin_async_a: assert property (!ext_reset_n_in |-> port_reset_out && cpu_reset_out)
      else $error("pin low without reset");
   por_hold_a: assert property (supply_low_in |-> cpu_reset_out && port_reset_out)
      else $error("supply low without reset");
   bod_trip_a: assert property (bod_on && avcc_low_in |-> port_reset_out)
      else $error("brown-out without reset");
   tap_hold_a: assert property (tap_reset_in |-> cpu_reset_out)
      else $error("test port reset dropped");
   ref_on_a: assert property (ref_c ##1 ref_c |-> ref_enable_out)
      else $error("reference off while needed");
   ref_off_a: assert property (!ref_c ##1 !ref_c |-> !ref_enable_out)
      else $error("reference on while unused");
   wdt_hit_a: assert property ($rose(wdt_timeout_in) && wdt_enable_in |-> ##[1:4] cpu_reset_out)
      else $error("watchdog expiry ignored");
   // Shortest fuse holds reset for at least eight cycles after release
   stretch_a: assert property ($fell(any_s) |-> cpu_reset_out [*8])
      else $error("reset not stretched");
   port_first_a: assert property (!cpu_reset_out |-> !port_reset_out)
      else $error("port reset outlives core reset");
   cover property ($fell(cpu_reset_out));
   cover property ($rose(wdt_timeout_in) && wdt_enable_in);
   cover property (ref_enable_out && !bod_on);
endmodule : srrc_props
bind srrc_top srrc_props u_props (.*);
`default_nettype wire

/* testbench/srrc_far_model.sv */
// Far side: supply detectors, reset pin, watchdog, test port.
// Assumes the bench calls pulse(); sources are idle otherwise.
`default_nettype none
module srrc_far_model (
   input  wire logic clk_sys_in,              // Clock
   output var logic  supply_low_out  = 1'b0,  // Supply low
   output var logic  ext_reset_n_out = 1'b1,  // Pin
   output var logic  wdt_timeout_out = 1'b0,  // Expiry
   output var logic  avcc_low_out    = 1'b0,  // Brown-out
   output var logic  tap_reset_out   = 1'b0   // Test port
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Source pulses
   // ----------------------------------------
   function automatic void drive(input int src, input logic on);
      case (src)
         0: supply_low_out = on;
         1: ext_reset_n_out = ~on;
         2: wdt_timeout_out = on;
         3: avcc_low_out = on;
         default: tap_reset_out = on;
      endcase
   endfunction : drive
   // Pin pulses span whole cycles, above any minimum width
   task automatic pulse(input int src, input int n);
      @(negedge clk_sys_in);
      drive(src, 1'b1);
      repeat (n) @(negedge clk_sys_in);
      drive(src, 1'b0);
   endtask : pulse
endmodule : srrc_far_model
`default_nettype wire

/* testbench/srrc_tb.sv */
// Self-checking bench for the reset and reference controller.
// Assumes the design and far-side model; fuses start at shortest delay.
`default_nettype none
module srrc_tb;
   import srrc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in = 1'b0, rst_in = 1'b1, wen = 1'b0, comparator_bandgap_select = 1'b0, adc = 1'b0, wclr = 1'b0, pclr = 1'b0;
   logic [2:0]  bodf = 3'h7;
   logic [3:0]  cks = 4'h0;
   logic        sl, xr, wt, al, tp, prst, crst, ref_o;
   srrc_flags_t flg;
   int          n_mismatch = 0, n_compared = 0;
   always #5 clk_sys_in = ~clk_sys_in;
   srrc_far_model far (.clk_sys_in, .supply_low_out(sl), .ext_reset_n_out(xr), .wdt_timeout_out(wt),
      .avcc_low_out(al), .tap_reset_out(tp));
   srrc_top dut (.clk_sys_in, .rst_in, .supply_low_in(sl), .ext_reset_n_in(xr), .wdt_timeout_in(wt),
      .wdt_enable_in(wen), .avcc_low_in(al), .brownout_level_fuse_in(bodf), .tap_reset_in(tp),
      .startup_time_fuse_in(2'h0), .clock_select_fuse_in(cks), .comparator_bandgap_select_in(comparator_bandgap_select),
      .adc_enable_in(adc), .wdt_flag_clr_in(wclr), .por_flag_clr_in(pclr), .port_reset_out(prst),
      .cpu_reset_out(crst), .ref_enable_out(ref_o), .flags_out(flg));
   // ----------------------------------------
   // Checks and tests
   // ----------------------------------------
   task automatic chk(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk
   // Slack covers watchdog pulse and synchroniser edges
   task automatic run_wait(input int dly);
      int n;
      n = 0;
      while (crst !== 1'b0 && n < dly + 20) begin
         @(negedge clk_sys_in);
         n++;
      end
      chk(n >= dly + 3 && n <= dly + 7, 1'b1);
   endtask : run_wait
   task automatic print_verdict;
      $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   initial begin
      #200us;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      repeat (10) @(negedge clk_sys_in);
      rst_in = 1'b0;
      run_wait(4);
      chk(prst, 1'b0);
      far.pulse(1, 3);
      chk(crst, 1'b1);
      run_wait(4);
      far.pulse(1, 3);
      repeat (5) @(negedge clk_sys_in);
      far.pulse(1, 3);
      run_wait(4);
      far.pulse(0, 3);
      chk(flg.por_flag, 1'b1);
      run_wait(4);
      pclr = 1'b1;
      @(negedge clk_sys_in);
      pclr = 1'b0;
      chk(flg.por_flag, 1'b0);
      far.pulse(2, 1);
      repeat (6) @(negedge clk_sys_in);
      chk(crst, 1'b0);
      chk(flg.wdt_flag, 1'b0);
      wen = 1'b1;
      far.pulse(2, 1);
      repeat (3) @(negedge clk_sys_in);
      chk(crst, 1'b1);
      chk(flg.wdt_flag, 1'b1);
      // Three cycles of the stretch are already spent here
      run_wait(1);
      wclr = 1'b1;
      @(negedge clk_sys_in);
      wclr = 1'b0;
      chk(flg.wdt_flag, 1'b0);
      far.pulse(2, 1);
      repeat (3) @(negedge clk_sys_in);
      chk(flg.wdt_flag, 1'b1);
      run_wait(1);
      far.pulse(0, 3);
      chk(flg.wdt_flag, 1'b0);
      run_wait(4);
      far.pulse(3, 3);
      chk(crst, 1'b0);
      bodf = 3'h0;
      far.pulse(3, 3);
      chk(crst, 1'b1);
      run_wait(4);
      far.pulse(4, 20);
      chk(crst, 1'b1);
      run_wait(4);
      for (int i = 0; i < 8; i++) begin
         bodf = i[2] ? 3'h0 : 3'h7;
         comparator_bandgap_select = i[1];
         adc = i[0];
         repeat (2) @(negedge clk_sys_in);
         chk(ref_o, i != 0);
      end
      cks = 4'h1;
      far.pulse(1, 3);
      run_wait(1024);
      print_verdict();
   end
endmodule : srrc_tb
`default_nettype wire
